// *** apm_ctrl.sv ***
// How it works
// R1 - full shutdown powers everything down but keeps the control word
// R2 - full shutdown lasts until a write changes the power select bits
// R3 - writing 11 in full shutdown starts power-up at that chip select rise
// R4 - track-and-hold goes back to track on the 14th falling edge
// R5 - host waits the wake delay before the next chip select fall
// R6 - power select 01 powers down after each conversion, held in hold
// R7 - auto shutdown wakes on the chip select fall, tracks again from the 14th falling edge
// R8 - host allows 1 us of wake time before trusting a result
// R9 - at 20 MHz one dummy read with write 0 wakes the part
// R10 - a transfer programming auto shutdown finishes its conversion first
// R11 - after supply, a dummy write of 11 then 1 us selects normal mode; here reset loads CTRL_INIT with power select 11 and wakes without a write
// R12 - a dummy write of 10 enters full shutdown at chip select rise
// R13 - two dummy writes, the second 01, enter auto shutdown
// R14 - chip select fall holds, enables data out, starts 16-clock conversion
// R15 - data out floats again on the 16th falling edge
// R16 - early chip select rise aborts, floats data out, keeps control word
// R17 - first bit on chip select fall, next bits on falling edges
// R18 - word is two zeros, channel tag, result padded with trailing zeros
// R19 - control bits load from the first 12 falling edges if write set
// R20 - serial clock is the only conversion clock
// R21 - power select 11 stays powered between transfers
// R22 - write flag 0 leaves the control word unchanged
// R23 - captured word commits at chip select rise after 16 clocks
`timescale 1ns/1ps
`default_nettype none

module apm_ctrl import apm_pkg::*; #(
  parameter int RES_BITS = 12,
  parameter logic [11:0] CTRL_RST = CTRL_INIT
) (
  // system clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // serial link
  input wire logic SCLK,
  input wire logic CS_B,
  input wire logic DIN,
  output logic DOUT,
  output logic DOUT_OE,
  // converter side
  input wire logic [RES_BITS-1:0] CONV_RESULT,
  output logic [1:0] CHAN_SEL,
  output logic [1:0] PWR_MODE,
  output logic POWERED,
  output logic TRACK,
  output logic READY
);

  // link-side frame state, cleared while chip select is high
  typedef struct packed {
    logic [4:0] cnt;
    logic dout;
    logic h14;
    logic end16;
  } apm_lk_s;

  // link-side capture, survives the frame end
  typedef struct packed {
    logic [CTRL_W-1:0] cap;
    logic done_tgl;
  } apm_cp_s;

  // system-side state
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    apm_pwr_e st;
    logic [WAKE_W-1:0] wcnt;
    logic powered;
    logic track;
    logic ready;
    logic done_seen;
    logic cs_q;
    logic tg_q;
  } apm_sy_s;

  apm_lk_s lk_r;
  apm_lk_s lk_nxt;
  apm_cp_s cp_r;
  apm_cp_s cp_nxt;
  apm_sy_s sy_r;
  apm_sy_s sy_nxt;
  logic lk_clr;
  logic oe_clr;
  logic oe_r;
  logic [15:0] word;
  logic [RES_FIELD-1:0] res_pad;
  logic cs_s;
  logic cs_act_s;
  logic tg_s;
  logic h14_s;
  logic cs_fall;
  logic cs_rise;
  logic tg_evt;
  logic complete;
  logic commit;
  logic [1:0] mode;

  // outgoing word
  always_comb begin
    res_pad = RES_FIELD'(CONV_RESULT) << (RES_FIELD - RES_BITS); // R18
    word = {2'b00, CHAN_SEL, res_pad}; // R18
  end

  // frame counter and shifter on the serial clock
  always_comb begin
    lk_nxt = lk_r;
    if (lk_r.cnt != CNT_FRAME) begin
      lk_nxt.cnt = lk_r.cnt + 5'h01; // R20
    end
    if (lk_r.cnt < CNT_LAST) begin
      lk_nxt.dout = word[DOUT_TOP - lk_r.cnt[3:0]]; // R17
    end
    if (lk_nxt.cnt == CNT_TRACK) begin
      lk_nxt.h14 = 1'b1; // R4
    end
    if (lk_nxt.cnt == CNT_FRAME) begin
      lk_nxt.end16 = 1'b1; // R15
      lk_nxt.dout = 1'b0;
    end
  end

  assign lk_clr = CS_B | ~RST_B;

  always_ff @(negedge SCLK or posedge lk_clr) begin
    if (lk_clr) begin
      lk_r <= '0; // R14
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // control bit capture and completion toggle
  always_comb begin
    cp_nxt = cp_r;
    if (!CS_B && lk_r.cnt < CNT_CAP) begin
      cp_nxt.cap = {cp_r.cap[CTRL_W-2:0], DIN}; // R19
    end
    if (!CS_B && lk_r.cnt == CNT_LAST) begin
      cp_nxt.done_tgl = ~cp_r.done_tgl;
    end
  end

  always_ff @(negedge SCLK or negedge RST_B) begin
    if (!RST_B) begin
      cp_r <= '0;
    end else begin
      cp_r <= cp_nxt;
    end
  end

  // data out enable: set by chip select fall, cleared at end or abort
  assign oe_clr = CS_B | lk_r.end16 | ~RST_B;

  always_ff @(negedge CS_B or posedge oe_clr) begin
    if (lk_r.end16 || !RST_B) begin
      oe_r <= 1'b0; // R15
    end else if (!CS_B) begin
      oe_r <= 1'b1; // R14
    end else begin
      oe_r <= 1'b0; // R16
    end
  end

  // crossing into the system clock; select synced active high so reset reads idle
  apm_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .d({~CS_B, cp_r.done_tgl, lk_r.h14}),
    .q({cs_act_s, tg_s, h14_s})
  );

  always_comb begin
    cs_s = ~cs_act_s;
    cs_fall = sy_r.cs_q & ~cs_s;
    cs_rise = ~sy_r.cs_q & cs_s;
    tg_evt = tg_s ^ sy_r.tg_q;
    complete = sy_r.done_seen | tg_evt;
    commit = cs_rise & complete & cp_r.cap[WR_BIT]; // R19 R22 R23
    mode = commit ? cp_r.cap[PWR_HI:PWR_LO] : sy_r.ctrl[PWR_HI:PWR_LO];
  end

  // power mode sequencing
  always_comb begin
    sy_nxt = sy_r;
    sy_nxt.cs_q = cs_s;
    sy_nxt.tg_q = tg_s;
    if (cs_fall || cs_rise) begin
      sy_nxt.done_seen = 1'b0;
    end
    if (tg_evt && !cs_rise) begin
      sy_nxt.done_seen = 1'b1;
    end
    if (commit) begin
      sy_nxt.ctrl = cp_r.cap; // R23
    end
    case (sy_r.st)
      APM_WAKE: begin
        if (sy_r.wcnt == WAKE_W'(WAKE_CYC - 1)) begin
          sy_nxt.st = APM_UP;
        end else begin
          sy_nxt.wcnt = sy_r.wcnt + WAKE_W'(1);
        end
      end
      APM_SLEEP: begin
        if (cs_fall) begin
          sy_nxt.st = APM_WAKE; // R7
          sy_nxt.wcnt = '0;
        end
      end
      APM_OFF: begin
        sy_nxt.st = APM_OFF; // R2
      end
      APM_UP: begin
        sy_nxt.st = APM_UP; // R21
      end
      default: begin
        sy_nxt.st = APM_OFF;
      end
    endcase
    if (cs_rise) begin
      case (mode)
        PWR_FULL: begin
          sy_nxt.st = APM_OFF; // R1 R12
        end
        PWR_AUTO: begin
          sy_nxt.st = APM_SLEEP; // R6 R10 R13
        end
        default: begin
          if (sy_r.st == APM_OFF || sy_r.st == APM_SLEEP) begin
            sy_nxt.st = APM_WAKE; // R3
            sy_nxt.wcnt = '0;
          end
        end
      endcase
    end
    sy_nxt.powered = sy_nxt.st == APM_WAKE || sy_nxt.st == APM_UP;
    sy_nxt.ready = sy_nxt.st == APM_UP;
    if (!cs_s) begin
      sy_nxt.track = h14_s; // R4 R14
    end else begin
      sy_nxt.track = sy_nxt.powered; // R6
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sy_r.ctrl <= CTRL_RST;
      sy_r.st <= APM_WAKE;
      sy_r.wcnt <= '0;
      sy_r.powered <= 1'b1;
      sy_r.track <= 1'b0;
      sy_r.ready <= 1'b0;
      sy_r.done_seen <= 1'b0;
      sy_r.cs_q <= 1'b1;
      sy_r.tg_q <= 1'b0;
    end else begin
      sy_r <= sy_nxt;
    end
  end

  // outputs
  assign DOUT = lk_r.dout;
  assign DOUT_OE = oe_r;
  assign CHAN_SEL = sy_r.ctrl[CHAN_HI:CHAN_LO];
  assign PWR_MODE = sy_r.ctrl[PWR_HI:PWR_LO];
  assign POWERED = sy_r.powered;
  assign TRACK = sy_r.track;
  assign READY = sy_r.ready;

  // checks on the system clock
  sequence s_end_full;
    cs_rise && mode == PWR_FULL;
  endsequence

  sequence s_end_auto;
    cs_rise && mode == PWR_AUTO;
  endsequence

  sequence s_wake_full;
    cs_rise && sy_r.st == APM_OFF && mode == PWR_NORMAL;
  endsequence

  a_full_down: assert property (@(posedge CLK) disable iff (!RST_B) // R1
    s_end_full |=> !POWERED && !TRACK && !READY)
    else $error("full shutdown did not power down");

  a_full_stays: assert property (@(posedge CLK) disable iff (!RST_B) // R2
    (sy_r.st == APM_OFF && !cs_rise) |=> sy_r.st == APM_OFF)
    else $error("full shutdown left without a write");

  a_full_wake: assert property (@(posedge CLK) disable iff (!RST_B) // R3
    s_wake_full |=> POWERED && !READY)
    else $error("power-up did not start at chip select rise");

  a_wake_time: assert property (@(posedge CLK) disable iff (!RST_B) // R3
    s_wake_full |=> !READY [*8])
    else $error("ready came before the wake delay");

  a_auto_sleep: assert property (@(posedge CLK) disable iff (!RST_B) // R6
    s_end_auto |=> !POWERED && !TRACK)
    else $error("auto shutdown did not sleep in hold");

  a_auto_wake: assert property (@(posedge CLK) disable iff (!RST_B) // R7
    (sy_r.st == APM_SLEEP && cs_fall) |=> POWERED)
    else $error("auto shutdown did not wake on chip select fall");

  a_abort_keep: assert property (@(posedge CLK) disable iff (!RST_B) // R16
    (cs_rise && !complete) |=> $stable(sy_r.ctrl))
    else $error("aborted transfer changed the control word");

  a_read_keep: assert property (@(posedge CLK) disable iff (!RST_B) // R22
    (cs_rise && !cp_r.cap[WR_BIT]) |=> $stable(sy_r.ctrl))
    else $error("write flag 0 changed the control word");

  a_commit_load: assert property (@(posedge CLK) disable iff (!RST_B) // R23
    commit |=> sy_r.ctrl == $past(cp_r.cap))
    else $error("complete write not committed");

  a_normal_up: assert property (@(posedge CLK) disable iff (!RST_B) // R21
    (sy_r.st == APM_UP && cs_rise && mode == PWR_NORMAL) |=> READY [*2])
    else $error("normal mode lost power");

  // checks on the serial clock
  a_lead_zero: assert property (@(negedge SCLK) disable iff (lk_clr) // R18
    (lk_r.cnt < CNT_ZEROS) |-> !DOUT)
    else $error("leading zero missing");

  a_tag_bits: assert property (@(negedge SCLK) disable iff (lk_clr) // R17
    (lk_r.cnt == CNT_TAG_HI) |-> DOUT == CHAN_SEL[1] ##1 DOUT == CHAN_SEL[0])
    else $error("channel tag out of place");

  a_oe_frame: assert property (@(negedge SCLK) disable iff (lk_clr) // R14
    (lk_r.cnt < CNT_FRAME) |-> DOUT_OE)
    else $error("data out not driven inside the frame");

  a_oe_end: assert property (@(posedge SCLK) disable iff (lk_clr) // R15
    (lk_r.cnt == CNT_FRAME) |-> lk_r.end16 && !DOUT_OE)
    else $error("data out still driven after the 16th edge");

  a_track_14: assert property (@(negedge SCLK) disable iff (lk_clr) // R4
    (lk_r.cnt == CNT_TRACK - 5'h01) |-> !lk_r.h14 ##1 lk_r.h14)
    else $error("track not restored on the 14th edge");

endmodule : apm_ctrl

`default_nettype wire

// *** apm_pkg.sv ***
package apm_pkg;

  // frame geometry, in falling serial clock edges
  localparam logic [4:0] CNT_FRAME = 5'h10;
  localparam logic [4:0] CNT_LAST = 5'h0f;
  localparam logic [4:0] CNT_CAP = 5'h0c;
  localparam logic [4:0] CNT_TRACK = 5'h0e;
  localparam logic [4:0] CNT_TAG_HI = 5'h02;
  localparam logic [4:0] CNT_ZEROS = 5'h02;
  localparam logic [3:0] DOUT_TOP = 4'he;

  // control word layout
  localparam int CTRL_W = 12;
  localparam int WR_BIT = 11;
  localparam int CHAN_HI = 9;
  localparam int CHAN_LO = 8;
  localparam int PWR_HI = 5;
  localparam int PWR_LO = 4;
  localparam logic [11:0] CTRL_INIT = 12'h030;

  // power select codes
  localparam logic [1:0] PWR_NORMAL = 2'h3;
  localparam logic [1:0] PWR_FULL = 2'h2;
  localparam logic [1:0] PWR_AUTO = 2'h1;

  // result field
  localparam int RES_FIELD = 12;

  // wake delay, least time, rounded up
  localparam int CLK_NS = 100;
  localparam int WAKE_NS = 1000;
  localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_W = 4;

  typedef enum logic [1:0] {
    APM_OFF,
    APM_SLEEP,
    APM_WAKE,
    APM_UP
  } apm_pwr_e;

endpackage : apm_pkg

// *** apm_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module apm_sync import apm_pkg::*; #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // levels in and out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] q;
  } apm_sync_s;

  apm_sync_s sy_r;
  apm_sync_s sy_nxt;

  always_comb begin
    sy_nxt.meta = d;
    sy_nxt.q = sy_r.meta;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sy_r <= '0;
    end else begin
      sy_r <= sy_nxt;
    end
  end

  assign q = sy_r.q;

endmodule : apm_sync

`default_nettype wire

// *** apm_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module apm_host (
  // link pins
  output var logic CS_B,
  output var logic SCLK,
  output var logic DIN,
  input wire logic DOUT,
  input wire logic DOUT_OE
);
  localparam realtime HALF = 62.5;

  initial begin
    CS_B = 1'b1;
    SCLK = 1'b1;
    DIN = 1'b0;
  end

  // one frame of n clocks, word msb first, clock idle high
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx,
                      output logic oe_end);
    rx = 16'h0000;
    CS_B = 1'b0;
    DIN = tx[15];
    #HALF;
    for (int k = 1; k <= n; k++) begin
      rx = {rx[14:0], DOUT_OE ? DOUT : 1'b1};
      SCLK = 1'b0;
      #HALF;
      SCLK = 1'b1;
      if (k < 16) begin
        DIN = tx[15-k];
      end
      #HALF;
    end
    oe_end = DOUT_OE;
    CS_B = 1'b1;
    DIN = ~DIN;
    #400;
  endtask : xfer
endmodule : apm_host

`default_nettype wire

// *** adc_serial_power_mode_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module adc_serial_power_mode_control_tb import apm_pkg::*;;
  logic CLK, RST_B, SCLK, CS_B, DIN, DOUT, DOUT_OE, POWERED, TRACK, READY, oe;
  logic [11:0] CONV_RESULT;
  logic [1:0] CHAN_SEL, PWR_MODE;
  logic [15:0] rx;
  int err_count = 0;
  int total_checks = 0;

  apm_ctrl #(.RES_BITS(12), .CTRL_RST(CTRL_INIT)) u_dut (
    .CLK(CLK), .RST_B(RST_B), .SCLK(SCLK), .CS_B(CS_B), .DIN(DIN), .DOUT(DOUT),
    .DOUT_OE(DOUT_OE), .CONV_RESULT(CONV_RESULT), .CHAN_SEL(CHAN_SEL),
    .PWR_MODE(PWR_MODE), .POWERED(POWERED), .TRACK(TRACK), .READY(READY));
  apm_host u_host (.CS_B(CS_B), .SCLK(SCLK), .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE));

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // one frame, then settle; word and float checked on full frames
  task automatic frame(input logic [11:0] ctrl, input logic [11:0] res, input int n,
                       input logic [1:0] tag);
    CONV_RESULT = res;
    u_host.xfer({ctrl, 4'h0}, n, rx, oe);
    if (n == 16) begin
      chk(rx, {2'b00, tag, res}, "word");
      chk(oe, 1'b0, "float at 16th");
    end
    repeat (5) @(posedge CLK);
    #1;
  endtask : frame

  task automatic mode(input logic [1:0] pm, input logic pw, input logic [1:0] ch);
    chk(PWR_MODE, pm, "mode");
    chk(POWERED, pw, "powered");
    chk(TRACK, pw, "track idle");
    chk(CHAN_SEL, ch, "channel");
  endtask : mode

  initial begin
    RST_B = 1'b0;
    CONV_RESULT = 12'h000;
    repeat (6) @(posedge CLK);
    #1 RST_B = 1'b1;
    repeat (12) @(posedge CLK);
    #1;
    chk(READY, 1'b1, "ready after reset");
    fork
      frame(12'ha30, 12'ha5c, 16, 2'h0);
      begin
        repeat (4) @(posedge CLK);
        #1;
        chk(TRACK, 1'b0, "hold in frame");
        chk(DOUT_OE, 1'b1, "drive in frame");
      end
    join
    mode(PWR_NORMAL, 1'b1, 2'h2);
    $display("normal write done");
    frame(12'h720, 12'h3c1, 16, 2'h2);
    mode(PWR_NORMAL, 1'b1, 2'h2);
    frame(12'h920, 12'h111, 9, 2'h2);
    chk(DOUT_OE, 1'b0, "abort float");
    mode(PWR_NORMAL, 1'b1, 2'h2);
    $display("no write and abort done");
    frame(12'h920, 12'hfff, 16, 2'h2);
    mode(PWR_FULL, 1'b0, 2'h1);
    frame(12'h7f0, 12'h800, 16, 2'h1);
    mode(PWR_FULL, 1'b0, 2'h1);
    frame(12'h930, 12'h001, 16, 2'h1);
    mode(PWR_NORMAL, 1'b1, 2'h1);
    chk(READY, 1'b0, "waking");
    repeat (6) @(posedge CLK);
    #1;
    chk(READY, 1'b1, "woken");
    $display("full shutdown done");
    frame(12'hfff, 12'h0f0, 16, 2'h1);
    frame(12'h910, 12'h5a5, 16, 2'h3);
    mode(PWR_AUTO, 1'b0, 2'h1);
    fork
      frame(12'h000, 12'h246, 16, 2'h1);
      begin
        repeat (4) @(posedge CLK);
        #1;
        chk(POWERED, 1'b1, "auto wake");
        chk(TRACK, 1'b0, "auto hold");
        repeat (10) @(posedge CLK);
        #1;
        chk(READY, 1'b1, "auto awake");
      end
    join
    mode(PWR_AUTO, 1'b0, 2'h1);
    frame(12'h000, 12'h000, 5, 2'h1);
    mode(PWR_AUTO, 1'b0, 2'h1);
    frame(12'h900, 12'h7e7, 16, 2'h1);
    mode(2'h0, 1'b1, 2'h1);
    $display("auto shutdown done");
    test_done();
  end

  initial begin
    #200000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end
endmodule : adc_serial_power_mode_control_tb

`default_nettype wire
